/* src/ssc_device.sv */
// Device end: two-wire management slave with its configuration registers.
`include "ssc_map.svh"
`default_nettype none
module ssc_device
	import ssc_pkg::*;
#(
	parameter int unsigned HIGH_MAX_CYCLES = `SSC_T_HIGH_MAX_NS / `SSC_CLK_PERIOD_NS
) (
	input  wire logic       mclk_in,
	input  wire logic       sys_rst_in,
	input  wire logic       clk_en_in,
	input  wire logic       management_mode_strap_in,
	input  wire logic [3:0] addr_sel_in,
	input  wire logic       eeprom_load_done_in,
	input  wire logic       power_down_pin_in,
	input  wire logic [7:0] check_expected_in,
	ssc_link_if.device      link,
	output logic      [7:0] per_channel_power_off_out,
	output logic      [7:0] equalizer_limit_select_out,
	output logic            channel_ctrl_unlocked_out,
	output logic            bus_idle_out
);

	localparam logic [12:0] BUF_CYCLES =
		13'((`SSC_T_BUF_NS + `SSC_CLK_PERIOD_NS - 1) / `SSC_CLK_PERIOD_NS);
	localparam logic [12:0] HIGH_CYCLES = 13'(HIGH_MAX_CYCLES);

	logic           scl_q;
	logic           sda_q;
	logic           scl_d;
	logic           sda_d;
	logic           strap_q;
	logic [3:0]     addr_sel_q;
	logic           scl_rise;
	logic           scl_fall;
	logic           start_seen;
	logic           stop_seen;
	ssc_dev_state_t state;
	logic [3:0]     bit_cnt;
	logic [7:0]     shift;
	logic           read_dir;
	logic [7:0]     index;
	logic [7:0]     own_addr;
	logic [7:0]     rd_value;
	logic [12:0]    high_cnt;
	logic           after_stop;
	logic [2:0]     obs_rw;
	logic [7:0]     pwr_off;
	logic [7:0]     pwr_block;
	logic [7:0]     eq_limit;
	logic [7:0]     check_val;
	logic [7:0]     slave_ctrl;
	logic           wr_strobe;

	// Line levels are synchronous to the clock; one stage plus a history stage.
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else if (clk_en_in) begin
			scl_q <= link.scl;
			sda_q <= link.sda;
			scl_d <= scl_q;
			sda_d <= sda_q;
		end
	end

	// Strap and select pins are caught by the clock after reset release.
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			strap_q    <= 1'b0;
			addr_sel_q <= 4'h0;
		end else if (clk_en_in) begin
			strap_q    <= management_mode_strap_in;
			addr_sel_q <= addr_sel_in;
		end
	end

	// Clock edges and the two bus conditions.
	assign scl_rise   = scl_q & ~scl_d;
	assign scl_fall   = ~scl_q & scl_d;
	assign start_seen = scl_q & scl_d & sda_d & ~sda_q;
	assign stop_seen  = scl_q & scl_d & ~sda_d & sda_q;

	// Own address byte: base plus twice the select value, direction bit cleared.
	assign own_addr = `SSC_ADDR_BASE + {3'h0, addr_sel_q, 1'b0};

	// Current contents of the register chosen by the index.
	always_comb begin
		case (index)
			`SSC_REG_OBSERVE: begin
				rd_value = {obs_rw[2], addr_sel_q, eeprom_load_done_in, obs_rw[1:0]};
			end
			`SSC_REG_PWR_OFF: begin
				rd_value = pwr_off;
			end
			`SSC_REG_PWR_BLOCK: begin
				rd_value = pwr_block;
			end
			`SSC_REG_EQ_LIMIT: begin
				rd_value = eq_limit;
			end
			`SSC_REG_CHECK: begin
				rd_value = check_val;
			end
			`SSC_REG_SLAVE_CTRL: begin
				rd_value = slave_ctrl;
			end
			default: begin
				rd_value = 8'h00;
			end
		endcase
	end

	// The data byte of a write lands when its eighth bit has been shifted in.
	assign wr_strobe = (state == DEV_WDATA) && scl_fall && (bit_cnt == 4'h8);

	// Transaction sequencer; the data pin only moves on a falling clock.
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state           <= DEV_IDLE;
			bit_cnt         <= 4'h0;
			shift           <= 8'h00;
			read_dir        <= 1'b0;
			index           <= 8'h00;
			link.dev_sda_oe  <= 1'b0;
			link.dev_sda_out <= 1'b0;
		end else if (clk_en_in) begin
			if (!strap_q) begin
				state          <= DEV_IDLE;
				link.dev_sda_oe <= 1'b0;
			end else if (start_seen) begin
				state          <= DEV_ADDR;
				bit_cnt        <= 4'h0;
				link.dev_sda_oe <= 1'b0;
			end else if (stop_seen) begin
				state          <= DEV_IDLE;
				link.dev_sda_oe <= 1'b0;
			end else begin
				case (state)
					DEV_ADDR, DEV_INDEX, DEV_WDATA: begin
						if (scl_rise) begin
							shift   <= {shift[6:0], sda_q};
							bit_cnt <= bit_cnt + 4'h1;
						end else if (scl_fall && bit_cnt == 4'h8) begin
							bit_cnt <= 4'h0;
							if (state == DEV_ADDR) begin
								if (shift[7:1] == own_addr[7:1]) begin
									read_dir       <= shift[0];
									state          <= DEV_AACK;
									link.dev_sda_oe <= 1'b1;
								end else begin
									state <= DEV_SKIP;
								end
							end else if (state == DEV_INDEX) begin
								index          <= shift;
								state          <= DEV_IACK;
								link.dev_sda_oe <= 1'b1;
							end else begin
								state          <= DEV_WACK;
								link.dev_sda_oe <= 1'b1;
							end
						end
					end
					DEV_AACK: begin
						if (scl_fall) begin
							if (read_dir) begin
								state           <= DEV_RDATA;
								shift           <= rd_value;
								link.dev_sda_oe  <= ~rd_value[7];
							end else begin
								state          <= DEV_INDEX;
								link.dev_sda_oe <= 1'b0;
							end
						end
					end
					DEV_IACK: begin
						if (scl_fall) begin
							state          <= DEV_WDATA;
							link.dev_sda_oe <= 1'b0;
						end
					end
					DEV_WACK: begin
						if (scl_fall) begin
							state          <= DEV_SKIP;
							link.dev_sda_oe <= 1'b0;
						end
					end
					DEV_RDATA: begin
						if (scl_fall) begin
							if (bit_cnt == 4'h7) begin
								state          <= DEV_MACK;
								link.dev_sda_oe <= 1'b0;
							end else begin
								bit_cnt        <= bit_cnt + 4'h1;
								shift          <= {shift[6:0], 1'b0};
								link.dev_sda_oe <= ~shift[6];
							end
						end
					end
					DEV_MACK: begin
						if (scl_rise) begin
							state <= DEV_SKIP;
						end
					end
					DEV_IDLE, DEV_SKIP: begin
						link.dev_sda_oe <= 1'b0;
					end
					default: begin
						state          <= DEV_IDLE;
						link.dev_sda_oe <= 1'b0;
					end
				endcase
			end
		end
	end

	// Both lines high: idle after the bus-free time past a stop, or the clock-high maximum.
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			high_cnt     <= 13'h0000;
			after_stop   <= 1'b0;
			bus_idle_out <= 1'b0;
		end else if (clk_en_in) begin
			if (stop_seen) begin
				after_stop <= 1'b1;
			end else if (start_seen) begin
				after_stop <= 1'b0;
			end
			if (!(scl_q && sda_q) || start_seen) begin
				high_cnt     <= 13'h0000;
				bus_idle_out <= 1'b0;
			end else begin
				if (high_cnt != 13'h1FFF) begin
					high_cnt <= high_cnt + 13'h0001;
				end
				if ((after_stop && high_cnt >= BUF_CYCLES) || high_cnt >= HIGH_CYCLES) begin
					bus_idle_out <= 1'b1;
				end
			end
		end
	end

	// Register file written by the single data byte of a write transaction.
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			obs_rw     <= 3'h0;
			pwr_off    <= `SSC_RST_PWR_OFF;
			pwr_block  <= `SSC_RST_PWR_BLOCK;
			eq_limit   <= `SSC_RST_EQ_LIMIT;
			check_val  <= `SSC_RST_CHECK;
			slave_ctrl <= `SSC_RST_SLAVE_CTRL;
		end else if (clk_en_in && wr_strobe) begin
			case (index)
				`SSC_REG_OBSERVE: begin
					obs_rw <= {shift[7], shift[1:0]}; // Read-only fields are kept out.
				end
				`SSC_REG_PWR_OFF: begin
					pwr_off <= shift;
				end
				`SSC_REG_PWR_BLOCK: begin
					pwr_block <= shift;
				end
				`SSC_REG_EQ_LIMIT: begin
					eq_limit <= shift;
				end
				`SSC_REG_CHECK: begin
					check_val <= shift;
				end
				`SSC_REG_SLAVE_CTRL: begin
					slave_ctrl <= shift;
				end
				default: begin
					obs_rw <= obs_rw;
				end
			endcase
		end
	end

	// Channel controls derived from the registers and the power-down pin.
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			per_channel_power_off_out  <= 8'h00;
			equalizer_limit_select_out <= 8'h00;
			channel_ctrl_unlocked_out  <= 1'b0;
		end else if (clk_en_in) begin
			if (pwr_block[`SSC_BLOCK_PIN_BIT]) begin
				per_channel_power_off_out <= pwr_off;
			end else begin
				per_channel_power_off_out <= pwr_off | {8{power_down_pin_in}};
			end
			equalizer_limit_select_out <= eq_limit;
			channel_ctrl_unlocked_out  <= slave_ctrl[`SSC_REG_ENABLE_BIT] ||
				(check_val == check_expected_in);
		end
	end

endmodule
`default_nettype wire

/* inc/ssc_map.svh */
// Register offsets, field positions, reset values and nanosecond bus timings of the management port.
`ifndef SSC_MAP_SVH
`define SSC_MAP_SVH

// Device register indexes reached over the two-wire link.
`define SSC_REG_OBSERVE       8'h00
`define SSC_REG_PWR_OFF       8'h01
`define SSC_REG_PWR_BLOCK     8'h02
`define SSC_REG_EQ_LIMIT      8'h04
`define SSC_REG_CHECK         8'h05
`define SSC_REG_SLAVE_CTRL    8'h06

// Device register reset values.
`define SSC_RST_OBSERVE       8'h00
`define SSC_RST_PWR_OFF       8'h00
`define SSC_RST_PWR_BLOCK     8'h00
`define SSC_RST_EQ_LIMIT      8'h00
`define SSC_RST_CHECK         8'h00
`define SSC_RST_SLAVE_CTRL    8'h10

// Device field positions.
`define SSC_OBS_ADDR_MSB      6
`define SSC_OBS_ADDR_LSB      3
`define SSC_OBS_LOAD_DONE     2
`define SSC_BLOCK_PIN_BIT     0
`define SSC_REG_ENABLE_BIT    3

// Address byte for all select inputs low; each select step adds two.
`define SSC_ADDR_BASE         8'hB0

// Bus timing in nanoseconds and the clock period.
`define SSC_CLK_PERIOD_NS     10
`define SSC_T_BUF_NS          4700
`define SSC_T_HIGH_MAX_NS     50000
`define SSC_T_QUARTER_NS      2500

// Controller Wishbone byte offsets.
`define SSC_WB_CMD            8'h00
`define SSC_WB_TARGET         8'h04
`define SSC_WB_INDEX          8'h08
`define SSC_WB_WDATA          8'h0C
`define SSC_WB_RDATA          8'h10
`define SSC_WB_STATUS         8'h14
`define SSC_WB_MASK           8'h18

// Controller field positions.
`define SSC_CMD_WRITE         0
`define SSC_CMD_READ          1
`define SSC_ST_DONE           0
`define SSC_ST_NACK           1
`define SSC_ST_BUSY           8

// Controller reset values.
`define SSC_RST_TARGET        7'h58

`endif

/* inc/ssc_pkg.sv */
// Types shared by both ends of the management link.
`default_nettype none
package ssc_pkg;

	// Device states, Gray coded along the usual path.
	typedef enum logic [3:0] {
		DEV_IDLE  = 4'h0,
		DEV_ADDR  = 4'h1,
		DEV_AACK  = 4'h3,
		DEV_INDEX = 4'h2,
		DEV_IACK  = 4'h6,
		DEV_WDATA = 4'h7,
		DEV_WACK  = 4'h5,
		DEV_RDATA = 4'h4,
		DEV_MACK  = 4'hC,
		DEV_SKIP  = 4'hD
	} ssc_dev_state_t;

	// Controller states, Gray coded along the usual path.
	typedef enum logic [2:0] {
		HST_IDLE  = 3'h0,
		HST_START = 3'h1,
		HST_BIT   = 3'h3,
		HST_STOP  = 3'h2,
		HST_GAP   = 3'h6
	} ssc_host_state_t;

endpackage
`default_nettype wire

/* inc/ssc_link_if.sv */
// Two-wire link between the controller and the device, with the wired-AND levels.
`default_nettype none
interface ssc_link_if;
	logic host_scl_out;
	logic host_scl_oe;
	logic host_sda_out;
	logic host_sda_oe;
	logic dev_sda_out;
	logic dev_sda_oe;
	logic scl;
	logic sda;

	// A driven pin pulls its line to the driven level; an undriven line floats high.
	assign scl = host_scl_oe ? host_scl_out : 1'b1;
	assign sda = (host_sda_oe ? host_sda_out : 1'b1) & (dev_sda_oe ? dev_sda_out : 1'b1);

	modport host (output host_scl_out, host_scl_oe, host_sda_out, host_sda_oe,
		input scl, sda);
	modport device (output dev_sda_out, dev_sda_oe, input scl, sda);
endinterface
`default_nettype wire

/* src/ssc_host.sv */
// Controller end: Wishbone-driven two-wire master issuing single-byte writes and reads.
`include "ssc_map.svh"
`default_nettype none
module ssc_host
	import ssc_pkg::*;
(
	input  wire logic        mclk_in,
	input  wire logic        sys_rst_in,
	input  wire logic        clk_en_in,
	input  wire logic        wb_cyc_in,
	input  wire logic        wb_stb_in,
	input  wire logic        wb_we_in,
	input  wire logic [7:0]  wb_adr_in,
	input  wire logic [3:0]  wb_sel_in,
	input  wire logic [31:0] wb_dat_in,
	output logic      [31:0] wb_dat_out,
	output logic             wb_ack_out,
	output logic             irq_out,
	ssc_link_if.host         link
);

	localparam logic [8:0] QCYC = 9'(`SSC_T_QUARTER_NS / `SSC_CLK_PERIOD_NS);

	ssc_host_state_t state;
	logic [8:0]      div;
	logic            tick;
	logic [1:0]      q;
	logic [3:0]      bit_no;
	logic [1:0]      byte_no;
	logic            is_read;
	logic            got_nack;
	logic [7:0]      shift;
	logic            rx_byte;
	logic [7:0]      tx_byte;
	logic [6:0]      target;
	logic [7:0]      index;
	logic [7:0]      wdata;
	logic [7:0]      rdata;
	logic [1:0]      status;
	logic [1:0]      mask;
	logic            wr_acc;
	logic            go_wr;
	logic            go_rd;
	logic            set_done;

	// A Wishbone write takes effect on the edge where ack is seen high.
	assign wr_acc = wb_cyc_in & wb_stb_in & wb_we_in & wb_ack_out & wb_sel_in[0];
	assign go_wr  = wr_acc && wb_adr_in == `SSC_WB_CMD && wb_dat_in[`SSC_CMD_WRITE];
	assign go_rd  = wr_acc && wb_adr_in == `SSC_WB_CMD && wb_dat_in[`SSC_CMD_READ];

	// Byte sent in each slot: address for write, index, then data or address for read.
	assign rx_byte = is_read && byte_no == 2'h3;
	always_comb begin
		case (byte_no)
			2'h0: tx_byte = {target, 1'b0};
			2'h1: tx_byte = index;
			2'h2: tx_byte = is_read ? {target, 1'b1} : wdata;
			default: tx_byte = 8'hFF;
		endcase
	end

	// Quarter-bit tick divider.
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			div  <= 9'h000;
			tick <= 1'b0;
		end else if (clk_en_in) begin
			tick <= (div == QCYC - 9'h001);
			div  <= (div == QCYC - 9'h001) ? 9'h000 : div + 9'h001;
		end
	end

	// Bus sequencer; each bit has four quarters: data set, clock high, sample, clock low.
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state             <= HST_IDLE;
			q                 <= 2'h0;
			bit_no            <= 4'h0;
			byte_no           <= 2'h0;
			is_read           <= 1'b0;
			got_nack          <= 1'b0;
			shift             <= 8'h00;
			rdata             <= 8'h00;
			set_done          <= 1'b0;
			link.host_scl_oe  <= 1'b0;
			link.host_scl_out <= 1'b0;
			link.host_sda_oe  <= 1'b0;
			link.host_sda_out <= 1'b0;
		end else if (clk_en_in) begin
			set_done <= 1'b0;
			if (state == HST_IDLE) begin
				if (go_wr || go_rd) begin
					state    <= HST_START;
					is_read  <= go_rd;
					byte_no  <= 2'h0;
					got_nack <= 1'b0;
					q        <= 2'h0;
				end
			end else if (tick) begin
				q <= q + 2'h1;
				case (state)
					HST_START: begin
						// Release data, release clock, data low under high clock, clock low.
						if (q == 2'h0) link.host_sda_oe <= 1'b0;
						if (q == 2'h1) link.host_scl_oe <= 1'b0;
						if (q == 2'h2) link.host_sda_oe <= 1'b1;
						if (q == 2'h3) begin
							link.host_scl_oe <= 1'b1;
							state            <= HST_BIT;
							bit_no           <= 4'h0;
							shift            <= tx_byte;
						end
					end
					HST_BIT: begin
						if (q == 2'h0) begin
							if (bit_no == 4'h8) begin
								link.host_sda_oe <= 1'b0;
							end else begin
								// Bit 0 takes the new byte directly, as shift is reloaded only now.
								link.host_sda_oe <= ~rx_byte &
									~((bit_no == 4'h0) ? tx_byte[7] : shift[7]);
							end
						end
						if (q == 2'h1) link.host_scl_oe <= 1'b0;
						if (q == 2'h2) begin
							if (bit_no == 4'h8) begin
								if (!rx_byte && link.sda) got_nack <= 1'b1;
							end else begin
								shift <= {shift[6:0], link.sda};
							end
						end
						if (q == 2'h3) begin
							link.host_scl_oe <= 1'b1;
							bit_no           <= bit_no + 4'h1;
							if (bit_no == 4'h8) begin
								byte_no <= byte_no + 2'h1;
								bit_no  <= 4'h0;
								if (rx_byte) rdata <= shift;
								if (got_nack || rx_byte || (!is_read && byte_no == 2'h2)) begin
									state <= HST_STOP;
								end else if (is_read && byte_no == 2'h1) begin
									state <= HST_START;
								end else begin
									shift <= (byte_no == 2'h2) ? 8'hFF : tx_byte;
								end
							end
						end
						if (q == 2'h0 && bit_no == 4'h0 && byte_no == 2'h1) shift <= tx_byte;
						if (q == 2'h0 && bit_no == 4'h0 && byte_no == 2'h2) shift <= tx_byte;
					end
					HST_STOP: begin
						if (q == 2'h0) link.host_sda_oe <= 1'b1;
						if (q == 2'h1) link.host_scl_oe <= 1'b0;
						if (q == 2'h2) link.host_sda_oe <= 1'b0;
						if (q == 2'h3) state <= HST_GAP;
					end
					HST_GAP: begin
						// Two more quarters of free bus before the next start.
						if (q == 2'h1) begin
							state    <= HST_IDLE;
							set_done <= 1'b1;
						end
					end
					default: begin
						state <= HST_IDLE;
					end
				endcase
			end else if (state == HST_BIT && bit_no == 4'h8) begin
				// Data is let go the clock after the line falls, so it never meets the ack.
				link.host_sda_oe <= 1'b0;
			end
		end
	end

	// Control registers, sticky status with write-one-clear, and the interrupt.
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			target  <= `SSC_RST_TARGET;
			index   <= 8'h00;
			wdata   <= 8'h00;
			status  <= 2'h0;
			mask    <= 2'h0;
			irq_out <= 1'b0;
		end else if (clk_en_in) begin
			if (wr_acc && wb_adr_in == `SSC_WB_TARGET) target <= wb_dat_in[6:0];
			if (wr_acc && wb_adr_in == `SSC_WB_INDEX) index <= wb_dat_in[7:0];
			if (wr_acc && wb_adr_in == `SSC_WB_WDATA) wdata <= wb_dat_in[7:0];
			if (wr_acc && wb_adr_in == `SSC_WB_MASK) mask <= wb_dat_in[1:0];
			// A completion in the clearing cycle wins over the clear.
			status[`SSC_ST_DONE] <= set_done |
				(status[`SSC_ST_DONE] & ~(wr_acc && wb_adr_in == `SSC_WB_STATUS &&
				wb_dat_in[`SSC_ST_DONE]));
			status[`SSC_ST_NACK] <= (set_done & got_nack) |
				(status[`SSC_ST_NACK] & ~(wr_acc && wb_adr_in == `SSC_WB_STATUS &&
				wb_dat_in[`SSC_ST_NACK]));
			irq_out <= |(status & mask);
		end
	end

	// Classic Wishbone answer: ack one cycle after the strobe, read data with it.
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			wb_ack_out <= 1'b0;
			wb_dat_out <= 32'h00000000;
		end else if (clk_en_in) begin
			wb_ack_out <= wb_cyc_in & wb_stb_in & ~wb_ack_out;
			case (wb_adr_in)
				`SSC_WB_TARGET: wb_dat_out <= {25'h0000000, target};
				`SSC_WB_INDEX:  wb_dat_out <= {24'h000000, index};
				`SSC_WB_WDATA:  wb_dat_out <= {24'h000000, wdata};
				`SSC_WB_RDATA:  wb_dat_out <= {24'h000000, rdata};
				`SSC_WB_STATUS: wb_dat_out <= {23'h000000, state != HST_IDLE, 6'h00, status};
				`SSC_WB_MASK:   wb_dat_out <= {30'h00000000, mask};
				default:        wb_dat_out <= 32'h00000000;
			endcase
		end
	end

endmodule
`default_nettype wire

/* test/ssc_link_assertions.sv */
// Wire-level checks on the two-wire link between controller and device.
`default_nettype none
module ssc_link_assertions (
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire logic scl,
	input wire logic sda,
	input wire logic host_sda_oe,
	input wire logic host_scl_oe,
	input wire logic dev_sda_oe,
	input wire logic dev_sda_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);

	// The device pin moves only while the clock line is low.
	dev_change_low_a: assert property ($changed(dev_sda_oe) |-> !scl)
		else $error("device data moved with clock high");
	// A data fall with the clock high is never caused by the device.
	dev_no_start_a: assert property ($fell(sda) && scl |-> !dev_sda_oe)
		else $error("device pulled data during clock high");
	// A driven bit is held well beyond one sample.
	dev_bit_hold_a: assert property ($rose(dev_sda_oe) |-> dev_sda_oe[*8])
		else $error("device bit too short");
	// The device only ever pulls the line low.
	dev_pull_low_a: assert property (dev_sda_oe |-> !dev_sda_out)
		else $error("device drove data high");
	// A start comes from the controller.
	start_by_host_a: assert property ($fell(sda) && scl |-> host_sda_oe)
		else $error("start not made by controller");
	// A stop is the controller letting go while nobody else pulls.
	stop_clean_a: assert property ($rose(sda) && scl |->
		$past(host_sda_oe) && !dev_sda_oe)
		else $error("bad stop condition");
	// Both parties never pull the data line at once.
	no_fight_a: assert property (dev_sda_oe |-> !host_sda_oe)
		else $error("both ends drive data");
	// The clock high phase lasts at least eight cycles, not a glitch.
	scl_high_min_a: assert property ($fell(host_scl_oe) |-> scl[*8])
		else $error("clock high too short");
	// Lines are released right after reset.
	idle_after_rst_a: assert property ($fell(sys_rst_in) |-> scl && sda)
		else $error("lines not idle after reset");
endmodule
`default_nettype wire

/* test/test_smbus_slave_config_port.sv */
// Self-checking bench for the controller and device joined by the link.
`include "ssc_map.svh"
`default_nettype none
module test_smbus_slave_config_port;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk_in;
	logic        sys_rst_in;
	logic        cyc;
	logic        stb;
	logic        we;
	logic        strap;
	logic        pin_pd;
	logic        ld_done;
	logic        ack;
	logic        irq;
	logic        unl;
	logic        idle;
	logic [3:0]  sel_pins;
	logic [7:0]  adr;
	logic [7:0]  chk;
	logic [7:0]  pwr;
	logic [7:0]  eq;
	logic [31:0] wdat;
	logic [31:0] rdat;
	logic [31:0] rd;
	int          bad_count;
	int          comparisons;
	ssc_link_if link ();

	ssc_host i_ssc_host (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .clk_en_in(1'b1),
		.wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF),
		.wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .irq_out(irq), .link(link));
	ssc_device #(.HIGH_MAX_CYCLES(600)) i_ssc_device (.mclk_in(mclk_in),
		.sys_rst_in(sys_rst_in), .clk_en_in(1'b1), .management_mode_strap_in(strap),
		.addr_sel_in(sel_pins), .eeprom_load_done_in(ld_done), .power_down_pin_in(pin_pd),
		.check_expected_in(chk), .link(link), .per_channel_power_off_out(pwr),
		.equalizer_limit_select_out(eq), .channel_ctrl_unlocked_out(unl), .bus_idle_out(idle));
	ssc_link_assertions i_ssc_link_assertions (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
		.scl(link.scl), .sda(link.sda), .host_sda_oe(link.host_sda_oe),
		.host_scl_oe(link.host_scl_oe), .dev_sda_oe(link.dev_sda_oe),
		.dev_sda_out(link.dev_sda_out));

	// Prints the counts and the verdict, then ends the run.
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Compares one value and reports a mismatch.
	task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string m);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask

	// One classic Wishbone cycle; read data lands in rd.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge mclk_in);
			n++;
		end while (ack !== 1'b1 && n < 20);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge mclk_in);
		if (n >= 20) begin
			bad_count++;
			give_verdict();
		end
	endtask

	// Polls status until the transfer is done, then leaves the status word in rd.
	task automatic wait_done();
		int n;
		n = 0;
		do begin
			wb(1'b0, `SSC_WB_STATUS, 32'h0);
			n++;
		end while (rd[0] !== 1'b1 && n < 20000);
		if (n >= 20000) begin
			bad_count++;
			give_verdict();
		end
	endtask

	// Reset values and the check-value unlock.
	task automatic t_reset();
		wb(1'b0, `SSC_WB_TARGET, 32'h0);
		check_val(rd, 32'h58, "target reset");
		wb(1'b0, 8'h1C, 32'h0);
		check_val(rd, 32'h0, "unmapped read");
		check_val(pwr, `SSC_RST_PWR_OFF, "power off reset");
		check_val(eq, `SSC_RST_EQ_LIMIT, "limit reset");
		check_val(unl, 1'b1, "unlock on match");
		chk <= 8'h3C;
		repeat (3) @(posedge mclk_in);
		check_val(unl, 1'b0, "lock on mismatch");
		$display("t_reset done");
	endtask

	// Register write over the link, pin gating and the interrupt.
	task automatic t_write(input logic [6:0] tgt);
		wb(1'b1, `SSC_WB_MASK, 32'h1);
		wb(1'b1, `SSC_WB_TARGET, {25'h0, tgt});
		wb(1'b1, `SSC_WB_INDEX, {24'h0, `SSC_REG_PWR_OFF});
		wb(1'b1, `SSC_WB_WDATA, 32'hA5);
		wb(1'b1, `SSC_WB_CMD, 32'h1);
		wait_done();
		check_val(rd[1], 1'b0, "write acked");
		check_val(pwr, 8'hA5, "power off bits");
		check_val(irq, 1'b1, "irq raised");
		pin_pd <= 1'b1;
		repeat (3) @(posedge mclk_in);
		check_val(pwr, 8'hFF, "pin allowed");
		pin_pd <= 1'b0;
		wb(1'b1, `SSC_WB_STATUS, 32'h3);
		repeat (3) @(posedge mclk_in);
		check_val(irq, 1'b0, "irq cleared");
		$display("t_write done");
	endtask

	// Register read with repeated start, then bus idle.
	task automatic t_read();
		wb(1'b1, `SSC_WB_INDEX, {24'h0, `SSC_REG_OBSERVE});
		wb(1'b1, `SSC_WB_CMD, 32'h2);
		wait_done();
		check_val(rd[1], 1'b0, "read acked");
		wb(1'b0, `SSC_WB_RDATA, 32'h0);
		check_val(rd, {24'h0, 1'b0, sel_pins, ld_done, 2'b00}, "observe reg");
		wb(1'b1, `SSC_WB_STATUS, 32'h3);
		repeat (600) @(posedge mclk_in);
		check_val(idle, 1'b1, "bus idle");
		$display("t_read done");
	endtask

	// Base address is refused when the select pins say otherwise.
	task automatic t_wrong();
		wb(1'b1, `SSC_WB_MASK, 32'h0);
		wb(1'b1, `SSC_WB_TARGET, {24'h0, `SSC_ADDR_BASE >> 1});
		wb(1'b1, `SSC_WB_CMD, 32'h1);
		wait_done();
		check_val(rd[1], 1'b1, "wrong address nacked");
		check_val(irq, 1'b0, "irq masked");
		check_val(pwr, 8'hA5, "no write on nack");
		$display("t_wrong done");
	endtask

	// With the strap low the device ignores even its own address.
	task automatic t_strap(input logic [6:0] tgt);
		strap <= 1'b0;
		wb(1'b1, `SSC_WB_TARGET, {25'h0, tgt});
		wb(1'b1, `SSC_WB_WDATA, 32'h5A);
		wb(1'b1, `SSC_WB_CMD, 32'h1);
		wait_done();
		check_val(rd[1], 1'b1, "strap low nacked");
		check_val(pwr, 8'hA5, "no write with strap low");
		strap <= 1'b1;
		$display("t_strap done");
	endtask

	// Free-running clock.
	initial begin
		mclk_in = 1'b0;
		forever #5 mclk_in = ~mclk_in;
	end

	// Main sequence.
	initial begin
		logic [7:0] abyte;
		bad_count = 0;
		comparisons = 0;
		sys_rst_in = 1'b1;
		{cyc, stb, we, pin_pd} = 4'h0;
		strap = 1'b1;
		ld_done = 1'b1;
		sel_pins = 4'hA;
		adr = 8'h00;
		chk = 8'h00;
		wdat = 32'h0;
		abyte = `SSC_ADDR_BASE + {3'h0, sel_pins, 1'b0};
		repeat (4) @(posedge mclk_in);
		sys_rst_in <= 1'b0;
		repeat (3) @(posedge mclk_in);
		t_reset();
		t_write(abyte[7:1]);
		t_read();
		t_wrong();
		t_strap(abyte[7:1]);
		give_verdict();
	end
endmodule
`default_nettype wire
